// ---- verilog/sink_driver.sv ----
`timescale 1ns/1ps
// Purpose: shift register, output latches and gating of a 16-channel sink driver
// Assumes: host pins and protection levels are synchronous to core_clk
// Notes:   sink_on bit high means that channel sinks current
module sink_driver (
  input  wire logic                        core_clk,
  input  wire logic                        reset,
  input  wire sink_driver_pkg::host_pins_t pins,
  input  wire sink_driver_pkg::protect_t   protect,
  output logic                             serial_out,
  output logic [15:0]                      sink_on,
  output logic                             bit_overflow
);
  import sink_driver_pkg::*;

  // ----------------------------------------------------------------
  // serial clock edges and lockout release
  // ----------------------------------------------------------------
  logic clk_rise;
  logic lockout_fall;

  edge_catch u_clk_edge (
    .core_clk (core_clk),
    .reset    (reset),
    .level    (pins.serial_clk),
    .rise     (clk_rise),
    .fall     ()
  );

  edge_catch u_lockout_edge (
    .core_clk (core_clk),
    .reset    (reset),
    .level    (protect.supply_low_lockout),
    .rise     (),
    .fall     (lockout_fall)
  );

  // ----------------------------------------------------------------
  // sampled bits queue up before the shift register
  // ----------------------------------------------------------------
  // one bit is drained per cycle, so the fifo only fills if edges come
  // faster than core_clk, which the sampling makes impossible; overflow
  // is still flagged rather than silently losing a bit
  logic fifo_ready;
  logic fifo_valid;
  logic fifo_bit;
  logic shift_en;

  bit_fifo #(
    .WIDTH (1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .reset     (reset),
    .flush     (lockout_fall),
    .in_data   (pins.serial_in),
    .in_valid  (clk_rise),
    .in_ready  (fifo_ready),
    .out_data  (fifo_bit),
    .out_valid (fifo_valid),
    .out_ready (1'b1)
  );

  assign shift_en = fifo_valid;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      bit_overflow <= 1'b0;
    end
    else if (clk_rise && !fifo_ready)
    begin
      bit_overflow <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // shift register
  // ----------------------------------------------------------------
  logic [15:0] shift_r;
  logic [15:0] latch_r;

  // keeps running under overheat; only reset and lockout release clear it
  always_ff @(posedge core_clk)
  begin
    if (reset || lockout_fall)
    begin
      shift_r <= CLEAR_WORD;
    end
    else if (shift_en)
    begin
      shift_r <= {shift_r[LAST_STAGE-1:0], fifo_bit};
    end
  end

  // stage 15 copy as its own flop keeps the output registered
  always_ff @(posedge core_clk)
  begin
    if (reset || lockout_fall)
    begin
      serial_out <= 1'b0;
    end
    else if (shift_en)
    begin
      serial_out <= shift_r[LAST_STAGE-1];
    end
  end

  // ----------------------------------------------------------------
  // output latches
  // ----------------------------------------------------------------
  // gate is not an input here, so it can never alter latch data
  always_ff @(posedge core_clk)
  begin
    if (reset || lockout_fall)
    begin
      latch_r <= CLEAR_WORD;
    end
    else if (pins.latch_transparent)
    begin
      latch_r <= shift_r;
    end
  end

  // ----------------------------------------------------------------
  // output gating
  // ----------------------------------------------------------------
  logic outputs_off;

  assign outputs_off = pins.output_gate_n
                    || protect.supply_low_lockout
                    || protect.overheat_shutdown;

  // one cycle behind the latch; the host must respect when bypassing
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      sink_on <= CLEAR_WORD;
    end
    else if (outputs_off)
    begin
      sink_on <= CLEAR_WORD;
    end
    else
    begin
      sink_on <= latch_r;
    end
  end
endmodule

// ---- common/sink_driver_pkg.sv ----
// Purpose: shared constants and carriers for the serial-in latched sink driver
// Assumes: serial clock, gate and latch pins are sampled on core_clk
package sink_driver_pkg;

  // ----------------------------------------------------------------
  // sizes and reset values
  // ----------------------------------------------------------------
  localparam int          CHANNELS    = 16;
  localparam int          LAST_STAGE  = 15;
  localparam int          FIFO_DEPTH  = 8;
  localparam logic [15:0] CLEAR_WORD  = 16'h0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic serial_clk;
    logic serial_in;
    logic latch_transparent;
    logic output_gate_n;
  } host_pins_t;

  typedef struct packed {
    logic supply_low_lockout;
    logic overheat_shutdown;
  } protect_t;

endpackage

// ---- verilog/bit_fifo.sv ----
`timescale 1ns/1ps
// Purpose: small valid/ready fifo on the serial bit path
// Assumes: single clock, synchronous active high reset plus flush
// Notes:   full and empty are exact; flush drops every held word
module bit_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  // pointer step shared by both ends of the ring
  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] ptr);
    return (ptr == AW'(DEPTH-1)) ? '0 : ptr + 1'b1;
  endfunction

  assign in_ready  = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data  = mem[rd_ptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset || flush)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= next_ptr(wr_ptr_r);
      end
      if (pop)
      begin
        rd_ptr_r <= next_ptr(rd_ptr_r);
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ---- verilog/edge_catch.sv ----
`timescale 1ns/1ps
// Purpose: rising and falling edge pulses of a level sampled on core_clk
// Assumes: input already synchronous to core_clk
// Notes:   reset loads the live level, so release never shows a false edge
module edge_catch (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic level,
  output logic      rise,
  output logic      fall
);
  logic prev_r;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      // a fixed value here gave a false lockout fall, flushing the first bit
      prev_r <= level;
    end
    else
    begin
      prev_r <= level;
    end
  end

  assign rise = level && !prev_r;
  assign fall = !level && prev_r;
endmodule

// ---- testbench/host_model.sv ----
// Purpose: host side of the serial and control pins
// Assumes: pins change at the falling edge of core_clk
// Notes:   data inverted after the hold so a stale bit shows up
`timescale 1ns/1ps
module host_model (
  input wire logic                   core_clk,
  output     sink_driver_pkg::host_pins_t pins
);
  import sink_driver_pkg::*;
  initial pins = 4'b0001;
  task automatic shift_bit(input logic b);
    @(negedge core_clk);
    pins.serial_in = b;
    @(negedge core_clk);
    pins.serial_clk = 1'b1;
    @(negedge core_clk);
    pins.serial_clk = 1'b0;
    pins.serial_in = ~b;
  endtask
  task automatic set_ctl(input logic lt, input logic gate_n);
    @(negedge core_clk);
    pins.latch_transparent = lt;
    pins.output_gate_n = gate_n;
  endtask
endmodule

// ---- testbench/sink_driver_asserts.sv ----
// Purpose: port checks of the sink driver
// Assumes: one clock domain, synchronous reset
// Notes:   windows of five cycles let the pin pipeline drain
`timescale 1ns/1ps
module sink_driver_asserts (
  input wire logic                        core_clk,
  input wire logic                        reset,
  input wire sink_driver_pkg::host_pins_t pins,
  input wire sink_driver_pkg::protect_t   protect,
  input wire logic                        serial_out,
  input wire logic [15:0]                 sink_on,
  input wire logic                        bit_overflow
);
  import sink_driver_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence open_s;
    (pins.latch_transparent && !pins.output_gate_n && protect == 2'b00 && !pins.serial_clk)[*5];
  endsequence
  sequence held_s;
    (!pins.latch_transparent && !pins.output_gate_n && protect == 2'b00)[*5];
  endsequence
  chk_gate_off: assert property (pins.output_gate_n |=> sink_on == 16'h0000)
    else $error("sink on with gate high");
  chk_lock_off: assert property (protect.supply_low_lockout |=> sink_on == 16'h0000)
    else $error("sink on in lockout");
  chk_heat_off: assert property (protect.overheat_shutdown |=> sink_on == 16'h0000)
    else $error("sink on in overheat");
  chk_follow_last: assert property (open_s |-> sink_on[15] == serial_out)
    else $error("last output differs from last stage");
  chk_latch_hold: assert property (held_s |-> $stable(sink_on))
    else $error("latch moved while closed");
  chk_out_edge: assert property ($changed(serial_out) |-> ($past(pins.serial_clk, 2)
    && !$past(pins.serial_clk, 3)) || $past(protect.supply_low_lockout, 2)
    || $past(protect.supply_low_lockout, 3))
    else $error("serial out moved without clock rise");
  chk_lock_clear: assert property ($fell(protect.supply_low_lockout) |->
    ##[1:3] serial_out == 1'b0)
    else $error("stages not cleared after lockout");
  chk_no_overflow: assert property (!bit_overflow)
    else $error("bit fifo overflow");
endmodule
bind sink_driver sink_driver_asserts i_sink_driver_asserts (.core_clk(core_clk), .reset(reset),
  .pins(pins), .protect(protect), .serial_out(serial_out), .sink_on(sink_on),
  .bit_overflow(bit_overflow));

// ---- testbench/sink_driver_bench.sv ----
// Purpose: self-checking bench of the sink driver
// Assumes: host model drives pins at the falling edge
// Notes:   settle covers the four-cycle path from pin to sink_on
`timescale 1ns/1ps
module sink_driver_bench;
  import sink_driver_pkg::*;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  host_pins_t  pins;
  protect_t    protect = 2'b00;
  logic        serial_out;
  logic [15:0] sink_on;
  logic [15:0] w1 = 16'ha5c3;
  logic [31:0] both = 32'ha5c3b296;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  always #12.5 core_clk = ~core_clk;
  host_model i_host_model (.core_clk(core_clk), .pins(pins));
  sink_driver i_sink_driver (.core_clk(core_clk), .reset(reset), .pins(pins),
    .protect(protect), .serial_out(serial_out), .sink_on(sink_on), .bit_overflow());
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic settle();
    repeat (5) @(negedge core_clk);
  endtask
  task automatic complete_run();
    $display("checks=%0d fails=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic t_load();
    for (int k = 0; k < 16; k++)
      i_host_model.shift_bit(w1[15-k]);
    settle();
    check(sink_on, 16'h0000);
    i_host_model.set_ctl(1'b1, 1'b0);
    i_host_model.set_ctl(1'b0, 1'b0);
    settle();
    check(sink_on, w1);
    i_host_model.set_ctl(1'b0, 1'b1);
    settle();
    check(sink_on, 16'h0000);
    i_host_model.set_ctl(1'b0, 1'b0);
    settle();
    check(sink_on, w1);
    $display("load and gate done");
  endtask
  task automatic t_shift();
    for (int k = 0; k < 16; k++)
    begin
      i_host_model.shift_bit(both[15-k]);
      repeat (3) @(negedge core_clk);
      check_bit(serial_out, both[30-k]);
    end
    check(sink_on, w1);
    $display("cascade done");
  endtask
  task automatic t_heat();
    protect.overheat_shutdown = 1'b1;
    i_host_model.set_ctl(1'b1, 1'b0);
    settle();
    check(sink_on, 16'h0000);
    protect.overheat_shutdown = 1'b0;
    settle();
    check(sink_on, both[15:0]);
    i_host_model.set_ctl(1'b0, 1'b0);
    $display("overheat done");
  endtask
  task automatic t_lock();
    protect.supply_low_lockout = 1'b1;
    settle();
    check(sink_on, 16'h0000);
    protect.supply_low_lockout = 1'b0;
    settle();
    check_bit(serial_out, 1'b0);
    check(sink_on, 16'h0000);
    i_host_model.set_ctl(1'b1, 1'b0);
    settle();
    check(sink_on, 16'h0000);
    i_host_model.set_ctl(1'b0, 1'b0);
    $display("lockout done");
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_fail++;
      complete_run();
    end
  end
  initial
  begin
    repeat (6) @(negedge core_clk);
    reset = 1'b0;
    t_load();
    t_shift();
    t_heat();
    t_lock();
    complete_run();
  end
endmodule
